// ### shared/spi_pkg.sv
package spi_pkg;
    // Register indices; byte address is index times four
    localparam logic [7:0] IDX_CONTROL_ONE = 8'h00;
    localparam logic [7:0] IDX_CONTROL_TWO = 8'h01;
    localparam logic [7:0] IDX_STATUS = 8'h03;
    localparam logic [7:0] IDX_DATA_HIGH = 8'h04;
    localparam logic [7:0] IDX_DATA_LOW = 8'h05;
    localparam logic [7:0] IDX_DATA_WORD = 8'h06;
    // Address slicing of the index
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned DECODE_TOP = IDX_LSB + IDX_W;
    // Status bit positions
    localparam int unsigned ST_RX_BIT = 7;
    localparam int unsigned ST_TX_BIT = 5;
    localparam int unsigned ST_MF_BIT = 4;
    // Control one bit positions
    localparam int unsigned C1_IE_BIT = 7;
    localparam int unsigned C1_EN_BIT = 6;
    localparam int unsigned C1_MASTER_BIT = 4;
    // Control two bit positions
    localparam int unsigned C2_WIDTH_BIT = 6;
    localparam int unsigned C2_FDE_BIT = 4;
    // Widths
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned PIN_N = 4;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned DIV_W = 16;
    // Reset values
    localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
    localparam logic [7:0] CONTROL_TWO_RST = 8'h00;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [3:0] PIN_IDLE = 4'h8;
    // Pin positions inside the synchroniser vector
    localparam int unsigned PIN_SCK = 0;
    localparam int unsigned PIN_MOSI = 1;
    localparam int unsigned PIN_MISO = 2;
    localparam int unsigned PIN_SS = 3;
    // Bits per frame
    localparam logic [4:0] BITS_NARROW = 5'h08;
    localparam logic [4:0] BITS_WIDE = 5'h10;
    // Bus clock and default serial clock half period in bus cycles
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned SCK_HALF_DEFAULT = 4;
    // Shifter states
    typedef enum logic {
        SH_IDLE = 1'b0,
        SH_RUN = 1'b1
    } shift_state_t;
endpackage : spi_pkg

// ### shared/shift_if.sv
`timescale 1ns/1ps
`default_nettype none
// Link between the register block and the shift engine
interface shift_if #(
    parameter int unsigned DATA_W = 16
);
    logic load; // Start a frame with load_data
    logic abort; // Force the engine idle
    logic wide; // Sixteen bit frame when high
    logic sample_en; // Latch the serial input
    logic shift_en; // Shift the latched bit in
    logic sin; // Serial input bit
    logic sout; // Serial output bit
    logic done; // One cycle pulse at frame end
    logic busy; // Frame in progress
    logic [DATA_W-1:0] load_data; // Word to send
    logic [DATA_W-1:0] rx_word; // Word received
    modport ctrl (
        output load, abort, wide, sample_en, shift_en, sin, load_data,
        input sout, done, busy, rx_word
    );
    modport engine (
        input load, abort, wide, sample_en, shift_en, sin, load_data,
        output sout, done, busy, rx_word
    );
endinterface : shift_if
`default_nettype wire

// ### src/spi_shifter.sv
`timescale 1ns/1ps
`default_nettype none
// Shift engine: loads a word, samples and shifts on enables, reports a frame
module spi_shifter (
    input wire logic clk,
    input wire logic rst_n,
    shift_if.engine sh
);
    spi_pkg::shift_state_t state_ff, nxt_state; // Engine state
    logic [spi_pkg::DATA_W-1:0] sreg_ff, nxt_sreg; // Shift register
    logic [spi_pkg::DATA_W-1:0] rx_ff, nxt_rx; // Captured frame
    logic [spi_pkg::CNT_W-1:0] cnt_ff, nxt_cnt; // Bits shifted so far
    logic bit_ff, nxt_bit; // Latched input bit
    logic done_ff, nxt_done; // Frame end pulse
    logic [spi_pkg::CNT_W-1:0] nbits; // Frame length
    logic [spi_pkg::DATA_W-1:0] shifted; // Register after one shift

    // Next state of the engine
    always_comb begin
        nbits = sh.wide ? spi_pkg::BITS_WIDE : spi_pkg::BITS_NARROW;
        // A bit latched in the shift cycle itself goes straight in
        shifted = {sreg_ff[spi_pkg::DATA_W-2:0], sh.sample_en ? sh.sin : bit_ff};
        nxt_state = state_ff;
        nxt_sreg = sreg_ff;
        nxt_rx = rx_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_done = 1'b0;
        unique case (state_ff)
            spi_pkg::SH_IDLE: begin
                // New frame
                if (sh.load && !sh.abort) begin
                    nxt_sreg = sh.load_data;
                    nxt_cnt = '0;
                    nxt_state = spi_pkg::SH_RUN;
                end
            end
            spi_pkg::SH_RUN: begin
                if (sh.abort) begin
                    // Aborted frames raise no done and leave rx_word alone; shift register and count keep their values
                    nxt_state = spi_pkg::SH_IDLE;
                end else begin
                    // Latch on the first edge of each bit
                    if (sh.sample_en) begin
                        nxt_bit = sh.sin;
                    end
                    // Shift on the second edge, count bits
                    if (sh.shift_en) begin
                        nxt_sreg = shifted;
                        nxt_cnt = cnt_ff + 5'h01;
                        if (nxt_cnt == nbits) begin
                            nxt_state = spi_pkg::SH_IDLE;
                            nxt_done = 1'b1;
                            nxt_rx = sh.wide ? shifted : {8'h00, shifted[spi_pkg::BYTE_W-1:0]};
                        end
                    end
                end
            end
        endcase
    end

    // Engine registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= spi_pkg::SH_IDLE;
            sreg_ff <= spi_pkg::DATA_RST;
            rx_ff <= spi_pkg::DATA_RST;
            cnt_ff <= '0;
            bit_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sreg_ff <= nxt_sreg;
            rx_ff <= nxt_rx;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            done_ff <= nxt_done;
        end
    end

    // Busy covers the done cycle so no new frame races the capture
    assign sh.busy = (state_ff == spi_pkg::SH_RUN) || done_ff;
    assign sh.done = done_ff;
    assign sh.rx_word = rx_ff;
    assign sh.sout = sh.wide ? sreg_ff[spi_pkg::DATA_W-1] : sreg_ff[spi_pkg::BYTE_W-1];
endmodule : spi_shifter
`default_nettype wire

// ### src/spi_status_data.sv
// Overview of operation
// - Receive flag sets when data reaches register
// - Transmit empty flag mirrors transmit register state
// - Master slave-select low with detection sets fault
// - Status read then control one write clears fault
// - Status readable anytime, writes to it ignored
// - Status read then low byte read clears receive
// - High byte reads never touch receive flag
// - Status read then low write clears empty
// - Data writes while not empty are dropped
// - High byte writes never touch empty flag
// - One address: receive on read, transmit write
// - Master sends queued data right after previous
// - Frame end with flag clear copies, sets flag
// - Second value waits until next frame starts
// - Service while waiting moves value, flag stays
// - Third frame start discards the waiting value
// - Frame length follows the width select bit
// - Fault with interrupt enable raises request
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module spi_status_data #(
    parameter int unsigned ADDR_W = 12,
    parameter int unsigned SCK_HALF = spi_pkg::SCK_HALF_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic ss_n_i,
    output logic sck_o,
    output logic sck_oe,
    output logic mosi_o,
    output logic mosi_oe,
    output logic miso_o,
    output logic miso_oe,
    output logic ss_n_o,
    output logic ss_n_oe,
    output logic irq
);
    shift_if #(.DATA_W(spi_pkg::DATA_W)) sh (); // Link to the shift engine

    // Pin synchroniser, three stages and a filter
    logic [spi_pkg::PIN_N-1:0] pin_s1_ff, nxt_pin_s1;
    logic [spi_pkg::PIN_N-1:0] pin_s2_ff, nxt_pin_s2;
    logic [spi_pkg::PIN_N-1:0] pin_s3_ff, nxt_pin_s3;
    logic [spi_pkg::PIN_N-1:0] pin_flt_ff, nxt_pin_flt; // Accepted pin levels
    logic [spi_pkg::PIN_N-1:0] pin_prev_ff, nxt_pin_prev; // Previous accepted levels

    // Register state
    logic [7:0] ctrl1_ff, nxt_ctrl1; // Control one
    logic [7:0] ctrl2_ff, nxt_ctrl2; // Control two
    logic [15:0] rx_data_ff, nxt_rx_data; // Receive data register
    logic [15:0] pend_data_ff, nxt_pend_data; // Waiting second value
    logic [15:0] tx_data_ff, nxt_tx_data; // Transmit data register
    logic rx_flag_ff, nxt_rx_flag; // Receive complete
    logic rx_arm_ff, nxt_rx_arm; // Status read saw receive flag
    logic pend_ff, nxt_pend; // Waiting value is valid
    logic tx_empty_ff, nxt_tx_empty; // Transmit register empty
    logic tx_arm_ff, nxt_tx_arm; // Status read saw empty flag
    logic mf_flag_ff, nxt_mf_flag; // Mode fault
    logic mf_arm_ff, nxt_mf_arm; // Status read saw fault flag
    logic irq_ff, nxt_irq; // Interrupt request
    logic [31:0] prdata_ff, nxt_prdata; // Read data captured in setup

    // Serial clock generator
    logic [spi_pkg::DIV_W-1:0] div_ff, nxt_div;
    logic sck_ff, nxt_sck;

    // Decode and strobes
    logic [spi_pkg::IDX_W-1:0] idx; // Register index
    logic mapped; // Address hits a register
    logic setup_ph; // APB setup cycle
    logic access_ph; // APB access cycle, always ready
    logic rd_status, rd_low, wr_c1, wr_c2, wr_high, wr_low, is_word;
    logic [31:0] rd_value; // Value for the current address
    logic [7:0] status_val; // Status byte
    logic enabled, master, wide, fault_det, ie;
    logic ss_low; // Accepted slave-select level is low
    logic sck_rise, sck_fall; // Accepted serial clock edges
    logic half_end; // Divider reached half period
    logic mf_event; // Mode fault condition this cycle
    logic start; // A new frame starts this cycle
    logic service; // Receive flag serviced this cycle

    // Configuration fields
    assign enabled = ctrl1_ff[spi_pkg::C1_EN_BIT];
    assign master = ctrl1_ff[spi_pkg::C1_MASTER_BIT];
    assign ie = ctrl1_ff[spi_pkg::C1_IE_BIT];
    assign wide = ctrl2_ff[spi_pkg::C2_WIDTH_BIT];
    assign fault_det = ctrl2_ff[spi_pkg::C2_FDE_BIT];
    assign ss_low = !pin_flt_ff[spi_pkg::PIN_SS];

    // Synchroniser next values; stage one feeds only stage two
    always_comb begin
        nxt_pin_s1 = {ss_n_i, miso_i, mosi_i, sck_i};
        nxt_pin_s2 = pin_s1_ff;
        nxt_pin_s3 = pin_s2_ff;
        nxt_pin_prev = pin_flt_ff;
        for (int i = 0; i < spi_pkg::PIN_N; i++) begin
            // Accept a change once stages two and three agree
            nxt_pin_flt[i] = (pin_s2_ff[i] == pin_s3_ff[i]) ? pin_s3_ff[i] : pin_flt_ff[i];
        end
    end

    // Synchroniser registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_ff <= spi_pkg::PIN_IDLE;
            pin_s2_ff <= spi_pkg::PIN_IDLE;
            pin_s3_ff <= spi_pkg::PIN_IDLE;
            pin_flt_ff <= spi_pkg::PIN_IDLE;
            pin_prev_ff <= spi_pkg::PIN_IDLE;
        end else begin
            pin_s1_ff <= nxt_pin_s1;
            pin_s2_ff <= nxt_pin_s2;
            pin_s3_ff <= nxt_pin_s3;
            pin_flt_ff <= nxt_pin_flt;
            pin_prev_ff <= nxt_pin_prev;
        end
    end

    // APB decode; zero wait states, read data captured in setup
    always_comb begin
        idx = paddr[spi_pkg::IDX_LSB +: spi_pkg::IDX_W];
        setup_ph = psel && !penable;
        access_ph = psel && penable;
        mapped = (paddr[spi_pkg::IDX_LSB-1:0] == '0) && (paddr[ADDR_W-1:spi_pkg::DECODE_TOP] == '0) &&
                 (idx == spi_pkg::IDX_CONTROL_ONE || idx == spi_pkg::IDX_CONTROL_TWO ||
                  idx == spi_pkg::IDX_STATUS || idx == spi_pkg::IDX_DATA_HIGH ||
                  idx == spi_pkg::IDX_DATA_LOW || idx == spi_pkg::IDX_DATA_WORD);
        is_word = (idx == spi_pkg::IDX_DATA_WORD);
        rd_status = access_ph && mapped && !pwrite && (idx == spi_pkg::IDX_STATUS);
        // Low byte and word reads count as low reads; high reads do nothing
        rd_low = access_ph && mapped && !pwrite && (idx == spi_pkg::IDX_DATA_LOW || is_word);
        wr_c1 = access_ph && mapped && pwrite && (idx == spi_pkg::IDX_CONTROL_ONE);
        wr_c2 = access_ph && mapped && pwrite && (idx == spi_pkg::IDX_CONTROL_TWO);
        wr_high = access_ph && mapped && pwrite && (idx == spi_pkg::IDX_DATA_HIGH || is_word);
        wr_low = access_ph && mapped && pwrite && (idx == spi_pkg::IDX_DATA_LOW || is_word);
        status_val = '0;
        status_val[spi_pkg::ST_RX_BIT] = rx_flag_ff;
        status_val[spi_pkg::ST_TX_BIT] = tx_empty_ff;
        status_val[spi_pkg::ST_MF_BIT] = mf_flag_ff;
        rd_value = '0;
        if (mapped) begin
            unique case (idx)
                spi_pkg::IDX_CONTROL_ONE: rd_value[7:0] = ctrl1_ff;
                spi_pkg::IDX_CONTROL_TWO: rd_value[7:0] = ctrl2_ff;
                spi_pkg::IDX_STATUS: rd_value[7:0] = status_val;
                // Data address reads the receive side
                spi_pkg::IDX_DATA_HIGH: rd_value[7:0] = rx_data_ff[15:8];
                spi_pkg::IDX_DATA_LOW: rd_value[7:0] = rx_data_ff[7:0];
                default: rd_value[15:0] = rx_data_ff;
            endcase
        end
        nxt_prdata = setup_ph && !pwrite ? rd_value : prdata_ff;
    end

    // Divider for the master serial clock, idle low
    always_comb begin
        half_end = (div_ff == spi_pkg::DIV_W'(SCK_HALF - 1));
        nxt_div = div_ff;
        nxt_sck = sck_ff;
        if (!sh.busy || !master || start) begin
            nxt_div = '0;
            nxt_sck = 1'b0;
        end else if (half_end) begin
            nxt_div = '0;
            nxt_sck = !sck_ff;
        end else begin
            nxt_div = div_ff + 16'h0001;
        end
    end

    // Link control toward the shift engine
    always_comb begin
        // Mode fault while master with detection on
        mf_event = enabled && master && fault_det && ss_low;
        // Master starts as soon as the engine is free and data waits
        start = (enabled && master && !sh.busy && !tx_empty_ff && !mf_event) ||
                (enabled && !master && pin_prev_ff[spi_pkg::PIN_SS] && ss_low);
        if (master) begin
            sck_rise = sh.busy && half_end && sck_ff; // Latch late, the input path lags four cycles
            sck_fall = sh.busy && half_end && sck_ff;
        end else begin
            sck_rise = ss_low && pin_flt_ff[spi_pkg::PIN_SCK] && !pin_prev_ff[spi_pkg::PIN_SCK];
            sck_fall = ss_low && !pin_flt_ff[spi_pkg::PIN_SCK] && pin_prev_ff[spi_pkg::PIN_SCK];
        end
    end

    assign sh.load = start;
    assign sh.load_data = tx_data_ff;
    assign sh.abort = !enabled || mf_event || (!master && !ss_low);
    assign sh.wide = wide;
    assign sh.sample_en = sck_rise;
    assign sh.shift_en = sck_fall;
    assign sh.sin = master ? pin_flt_ff[spi_pkg::PIN_MISO] : pin_flt_ff[spi_pkg::PIN_MOSI];

    // Flags, data buffers and control next values
    always_comb begin
        nxt_ctrl1 = wr_c1 ? pwdata[7:0] : ctrl1_ff;
        nxt_ctrl2 = wr_c2 ? pwdata[7:0] : ctrl2_ff;
        nxt_rx_flag = rx_flag_ff;
        nxt_rx_data = rx_data_ff;
        nxt_rx_arm = rx_arm_ff;
        nxt_pend = pend_ff;
        nxt_pend_data = pend_data_ff;
        nxt_tx_data = tx_data_ff;
        nxt_tx_empty = tx_empty_ff;
        nxt_tx_arm = tx_arm_ff;
        nxt_mf_flag = mf_flag_ff;
        nxt_mf_arm = mf_arm_ff;
        // A status read arms each clear by the value it returned
        if (rd_status) begin
            nxt_rx_arm = prdata_ff[spi_pkg::ST_RX_BIT];
            nxt_tx_arm = prdata_ff[spi_pkg::ST_TX_BIT];
            nxt_mf_arm = prdata_ff[spi_pkg::ST_MF_BIT];
        end
        // Receive service: low read after an armed status read
        service = rd_low && rx_arm_ff;
        if (service) begin
            nxt_rx_arm = 1'b0;
            if (pend_ff) begin
                // Waiting value moves up, flag stays set
                nxt_rx_data = pend_data_ff;
                nxt_pend = 1'b0;
            end else begin
                nxt_rx_flag = 1'b0;
            end
        end else if (start && pend_ff) begin
            // Next frame began before service, value is lost
            nxt_pend = 1'b0;
        end
        // Frame end; a clear in the same cycle loses to the set
        if (sh.done) begin
            if (!nxt_rx_flag) begin
                nxt_rx_data = sh.rx_word;
                nxt_rx_flag = 1'b1;
            end else begin
                // Register untouched, value kept aside
                nxt_pend = 1'b1;
                nxt_pend_data = sh.rx_word;
            end
        end
        // High byte staging, only while empty; flag untouched
        if (wr_high && tx_empty_ff) begin
            nxt_tx_data[15:8] = is_word ? pwdata[15:8] : pwdata[7:0];
        end
        // Low byte write after an armed status read queues data
        if (wr_low && tx_empty_ff && tx_arm_ff) begin
            nxt_tx_data[7:0] = pwdata[7:0];
            nxt_tx_empty = 1'b0;
            nxt_tx_arm = 1'b0;
        end
        // Data moved into the shift register empties the queue
        if (start && !tx_empty_ff) begin
            nxt_tx_empty = 1'b1;
        end
        // Fault clear by control one write, set wins
        if (wr_c1 && mf_arm_ff) begin
            nxt_mf_flag = 1'b0;
            nxt_mf_arm = 1'b0;
        end
        if (mf_event) begin
            nxt_mf_flag = 1'b1;
        end
        // Interrupt request from any flag under enable
        nxt_irq = ie && (rx_flag_ff || tx_empty_ff || mf_flag_ff);
    end

    // Register state, divider and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_ff <= spi_pkg::CONTROL_ONE_RST;
            ctrl2_ff <= spi_pkg::CONTROL_TWO_RST;
            rx_data_ff <= spi_pkg::DATA_RST;
            pend_data_ff <= spi_pkg::DATA_RST;
            tx_data_ff <= spi_pkg::DATA_RST;
            rx_flag_ff <= 1'b0;
            rx_arm_ff <= 1'b0;
            pend_ff <= 1'b0;
            tx_empty_ff <= 1'b1;
            tx_arm_ff <= 1'b0;
            mf_flag_ff <= 1'b0;
            mf_arm_ff <= 1'b0;
            irq_ff <= 1'b0;
            prdata_ff <= '0;
            div_ff <= '0;
            sck_ff <= 1'b0;
        end else begin
            ctrl1_ff <= nxt_ctrl1;
            ctrl2_ff <= nxt_ctrl2;
            rx_data_ff <= nxt_rx_data;
            pend_data_ff <= nxt_pend_data;
            tx_data_ff <= nxt_tx_data;
            rx_flag_ff <= nxt_rx_flag;
            rx_arm_ff <= nxt_rx_arm;
            pend_ff <= nxt_pend;
            tx_empty_ff <= nxt_tx_empty;
            tx_arm_ff <= nxt_tx_arm;
            mf_flag_ff <= nxt_mf_flag;
            mf_arm_ff <= nxt_mf_arm;
            irq_ff <= nxt_irq;
            prdata_ff <= nxt_prdata;
            div_ff <= nxt_div;
            sck_ff <= nxt_sck;
        end
    end

    // Shift engine
    spi_shifter u_shifter (
        .clk(pclk),
        .rst_n(presetn),
        .sh(sh.engine)
    );

    // Bus answers
    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;

    // Pins: master drives clock and data out; slave drives data only when selected
    assign sck_o = sck_ff;
    assign sck_oe = enabled && master;
    assign mosi_o = sh.sout;
    assign mosi_oe = enabled && master;
    assign miso_o = sh.sout;
    assign miso_oe = enabled && !master && ss_low;
    // Slave-select is an output only when fault detection is off
    assign ss_n_o = !sh.busy;
    assign ss_n_oe = enabled && master && !fault_det;
    assign irq = irq_ff;
endmodule : spi_status_data
`default_nettype wire

// ### verif/spi_status_data_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks of the status and data block
module spi_status_data_asserts #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sck_o,
    input wire logic mosi_o,
    input wire logic ss_n_o
);
    logic [4:0] edges_ff; // Clock rises in this frame
    logic [4:0] nxt_edges;
    logic sck_q_ff; // Clock one cycle ago
    logic acc; // Access phase
    assign acc = psel && penable;
    // Count clock rises while selected
    always_comb begin
        nxt_edges = ss_n_o ? 5'h00 : edges_ff + 5'(sck_o && !sck_q_ff);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edges_ff <= 5'h00;
            sck_q_ff <= 1'b0;
        end else begin
            edges_ff <= nxt_edges;
            sck_q_ff <= sck_o;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_always: assert property (psel |-> pready) else $error("ready low");
    a_status_clean: assert property (acc && paddr == 12'h00C |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("status access bad");
    a_data_clean: assert property (acc && paddr[11:3] == 9'h002 |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("data access bad");
    a_word_upper: assert property (acc && paddr == 12'h018 |-> !pslverr && prdata[31:16] == 16'h0)
        else $error("word access bad");
    a_unmapped_err: assert property (acc && paddr == 12'h008 |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped not refused");
    a_frame_bits: assert property ($rose(ss_n_o) |-> edges_ff == 5'h08 || edges_ff == 5'h10)
        else $error("frame length bad");
    a_sck_idle: assert property (ss_n_o |-> !sck_o) else $error("clock outside frame");
    a_mosi_steady: assert property (sck_o && $past(sck_o) |-> $stable(mosi_o))
        else $error("data moved while clock high");
endmodule : spi_status_data_asserts
bind spi_status_data spi_status_data_asserts #(.ADDR_W(ADDR_W)) u_spi_status_data_asserts (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .sck_o, .mosi_o, .ss_n_o);
`default_nettype wire

// ### verif/spi_remote_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Remote slave: mode 0, MSB first, any frame length
module spi_remote_slave (
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso
);
    logic [15:0] tab [4]; // Word returned in each frame
    logic [15:0] got [4]; // Word captured in each frame
    logic [15:0] sh; // Outgoing shifter
    logic [15:0] rx; // Incoming shifter
    logic sel = 1'b0; // Frame open
    int idx = 0; // Frame number
    initial miso = 1'b0;
    // Selection presents the first bit
    always @(negedge ss_n) begin
        sel = 1'b1;
        sh = tab[idx];
        miso = sh[15];
    end
    // Sample on rise, shift on fall
    always @(posedge sck) if (sel) rx = {rx[14:0], mosi};
    always @(negedge sck) if (sel) begin
        sh = {sh[14:0], 1'b0};
        miso = sh[15];
    end
    // Released line shows no stale value
    always @(posedge ss_n) if (sel) begin
        sel = 1'b0;
        got[idx] = rx;
        idx++;
        miso = ~miso;
    end
endmodule : spi_remote_slave
`default_nettype wire

// ### verif/spi_status_data_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("wrong value %0t: %h not %h", $time, g, e); end end
module spi_status_data_tb_top;
    logic pclk, presetn, psel, penable, pwrite, ss_n_i, miso_i, pready, pslverr, sck_o, mosi_o, ss_n_o, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, exp_v;
    logic [7:0] d0, d1, d2, d3, s0, s1, s3; // Random bytes out and back
    logic [15:0] w, sw; // Wide frame words
    logic [31:0] exp_q[$]; // Expected read data
    int err_count = 0;
    int n_checks = 0;
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    spi_status_data #(.ADDR_W(12), .SCK_HALF(4)) u_spi_status_data (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sck_i(1'b0), .mosi_i(1'b0), .miso_i, .ss_n_i, .sck_o,
        .sck_oe(), .mosi_o, .mosi_oe(), .miso_o(), .miso_oe(), .ss_n_o, .ss_n_oe(), .irq);
    spi_remote_slave u_spi_remote_slave (.sck(sck_o), .ss_n(ss_n_o), .mosi(mosi_o), .miso(miso_i));
    // Each read result against the oldest note
    always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
        exp_v = exp_q.pop_front();
        `CHK(prdata, exp_v)
    end
    task automatic stop_test;
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic hang;
        err_count++;
        stop_test();
    endtask : hang
    // One bus transfer, held until ready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) hang();
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // Wait until select stays high for eight cycles
    task automatic wait_idle;
        int n, q;
        n = 0;
        q = 0;
        while (q < 8) begin
            @(posedge pclk);
            q = (ss_n_o === 1'b1) ? q + 1 : 0;
            n++;
            if (n > 3000) hang();
        end
    endtask : wait_idle
    initial begin
        void'($urandom(32'h72a8));
        {psel, penable, pwrite, paddr, pwdata, ss_n_i, presetn} = 49'h2;
        {d0, d1, d2, d3} = $urandom;
        {s0, s1, s3} = 24'($urandom);
        {w, sw} = $urandom;
        u_spi_remote_slave.tab = '{{s0, 8'h00}, {s1, 8'h00}, {s3, 8'h00}, sw};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b1, 12'h000, 32'h50); // Enabled master
        apb(1'b1, 12'h004, 32'h00); // Narrow frames
        rd(12'h008, 32'h0); // Unmapped
        apb(1'b1, 12'h00C, 32'hFF); // Ignored write
        rd(12'h00C, 32'h20);
        apb(1'b1, 12'h010, 32'h5A); // High first
        rd(12'h00C, 32'h20);
        apb(1'b1, 12'h014, {24'h0, d0});
        repeat (4) @(posedge pclk);
        rd(12'h00C, 32'h20);
        apb(1'b1, 12'h014, {24'h0, d1}); // Queued
        rd(12'h00C, 32'h00);
        apb(1'b1, 12'h014, {24'h0, d2}); // Dropped
        wait_idle();
        rd(12'h00C, 32'hA0);
        apb(1'b1, 12'h014, {24'h0, d3}); // Third frame
        wait_idle();
        rd(12'h010, 32'h0);
        rd(12'h010, 32'h0);
        rd(12'h014, {24'h0, s0});
        rd(12'h00C, 32'hA0);
        rd(12'h014, {24'h0, s3});
        rd(12'h00C, 32'h20);
        apb(1'b1, 12'h004, 32'h10); // Fault detection on
        ss_n_i <= 1'b0;
        repeat (8) @(posedge pclk);
        ss_n_i <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(12'h00C, 32'h30);
        apb(1'b1, 12'h000, 32'hD0); // Interrupts on
        rd(12'h00C, 32'h20);
        `CHK(irq, 1'b1)
        apb(1'b1, 12'h004, 32'h40); // Wide frames
        rd(12'h00C, 32'h20);
        apb(1'b1, 12'h018, {16'h0, w});
        wait_idle();
        rd(12'h00C, 32'hA0);
        rd(12'h018, {16'h0, sw});
        rd(12'h00C, 32'h20);
        repeat (2) @(posedge pclk);
        `CHK(u_spi_remote_slave.got[0][7:0], d0)
        `CHK(u_spi_remote_slave.got[1][7:0], d1)
        `CHK(u_spi_remote_slave.got[2][7:0], d3)
        `CHK(u_spi_remote_slave.got[3], w)
        stop_test();
    end
endmodule : spi_status_data_tb_top
`default_nettype wire
